/* src/emhc_parser.sv */
`default_nettype none
// Contract
// - Area present only when flag set
// - Parameter byte carries area size
// - Area size from 1 to 240
// - Timing, concat, request carry no area
// - Frames inside concatenation may carry area
// - Frame size counts area plus payload
// - Order: fc, parm, size, area, check, payload
// - Area holds elements, type/size first byte
// - Size nibble gives payload bytes 0-15
// - Unknown elements skipped using size nibble
// - Reserved and undefined types ignored
// - Type 0 null pad, size 0
// - Type 1 request: slots, flow id
// - Type 2 acknowledge: flow id
// - Type 3 up privacy, 4 or 5
// - Type 4 down privacy, size 4
// - Types 5/6 suppression, 6 adds sync
// - Types 10-14 kept for forwarding
// - Type 15 escape: type, size, payload
// - Piggyback only in request, up privacy
module emhc_parser (
  input wire logic sys_clk, // Clock
  input wire logic rstn, // Async reset, active low
  emhc_link_if.rx link, // Incoming byte stream
  output logic hdr_valid, // Pulse: header fields below are updated
  output logic [7:0] fc_out, // Frame control byte
  output logic ext_present, // Area present
  output logic [7:0] ext_size, // Area size, 0 if absent
  output logic [15:0] frame_size, // Frame size field
  output logic [15:0] hcs_out, // Header check sequence
  output logic hdr_error, // Pulse: illegal area size/kind/size field
  output logic elem_valid, // Pulse: known element decoded
  output emhc_pkg::emhc_kind_t elem_kind, // Kind of element
  output logic [3:0] elem_type, // Type nibble (escape: low nibble ignored)
  output logic [7:0] elem_etype, // Escape element type
  output logic [39:0] elem_value, // First five payload bytes, first byte high; 0 for elements over five bytes
  output logic elem_bad_size, // Known type with wrong size
  output logic piggy_valid, // Pulse: piggyback request seen
  output logic [7:0] piggy_slots, // Requested mini-slots
  output logic fwd_valid, // Pulse: forwarded byte of end-to-end element
  output logic [7:0] fwd_byte, // Byte to keep for forwarding
  output logic pay_valid, // Pulse: payload byte
  output logic [7:0] pay_byte // Payload byte
);
  import emhc_pkg::*;
  typedef enum {P_FC, P_PARM, P_LHI, P_LLO, P_EH, P_EV, P_XT, P_XL, P_H1, P_H2, P_PAY,
    P_DROP} emhc_pst_t;
  emhc_pst_t st_ff;
  logic [7:0] area_ff, erem_ff, xtype_ff;
  logic [3:0] etype_ff, esize_ff;
  logic [2:0] idx_ff;
  logic [39:0] val_ff;
  logic e2e_ff;
  logic [7:0] b;
  logic last_area, elem_done, forbid;
  assign b = link.data;
  assign last_area = area_ff == 8'h01;
  assign forbid = (fc_out[7:6] == EMHC_FC_TYPE_MACSPEC) && ((fc_out[5:1] == EMHC_PARM_TIMING)
    || (fc_out[5:1] == EMHC_PARM_REQ) || (fc_out[5:1] == EMHC_PARM_CONCAT));
  // Element ends on its last payload byte
  assign elem_done = (st_ff == P_EV || st_ff == P_XL) && erem_ff == 8'h01;

  // Classify finished element; anything unrecognised just gets skipped
  function automatic emhc_kind_t kind_of(input logic [3:0] t, input logic [3:0] s);
    emhc_kind_t k;
    k = EMHC_K_SKIP;
    if (t == EMHC_T_REQ && s == EMHC_L_REQ) k = EMHC_K_REQ;
    else if (t == EMHC_T_ACK && s == EMHC_L_ACK) k = EMHC_K_ACK;
    else if (t == EMHC_T_UPRIV && (s == EMHC_L_PRIV || s == EMHC_L_PRIVFRAG))
      k = EMHC_K_UPRIV;
    else if (t == EMHC_T_DPRIV && s == EMHC_L_PRIV) k = EMHC_K_DPRIV;
    else if ((t == EMHC_T_DPHS && s == EMHC_L_PHS) ||
      (t == EMHC_T_UPHS && (s == EMHC_L_PHS || s == EMHC_L_PHSUGS))) k = EMHC_K_PHS;
    else if (t >= EMHC_T_E2E_LO && t <= EMHC_T_E2E_HI) k = EMHC_K_E2E;
    return k;
  endfunction

  // Frame walker
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= P_FC;
      area_ff <= 8'h00;
      erem_ff <= 8'h00;
      xtype_ff <= 8'h00;
      etype_ff <= 4'h0;
      esize_ff <= 4'h0;
      idx_ff <= 3'h0;
      val_ff <= 40'h0;
      e2e_ff <= 1'b0;
      fc_out <= 8'h00;
      ext_present <= 1'b0;
      ext_size <= 8'h00;
      frame_size <= 16'h0000;
      hcs_out <= 16'h0000;
      hdr_valid <= 1'b0;
      hdr_error <= 1'b0;
      pay_valid <= 1'b0;
      pay_byte <= 8'h00;
    end else begin
      hdr_valid <= 1'b0;
      hdr_error <= 1'b0;
      pay_valid <= 1'b0;
      if (link.valid) begin
        if (link.sof) begin
          // A new frame restarts the walk, so a broken frame cannot wedge it
          fc_out <= b;
          ext_present <= b[EMHC_FC_FLAG_BIT];
          st_ff <= P_PARM;
        end else begin
          area_ff <= area_ff - 8'h01;
          unique case (st_ff)
            P_FC: st_ff <= P_FC;
            P_PARM: begin
              ext_size <= ext_present ? b : 8'h00;
              area_ff <= b;
              st_ff <= P_LHI;
            end
            P_LHI: begin
              frame_size[15:8] <= b;
              st_ff <= P_LLO;
            end
            P_LLO: begin
              frame_size[7:0] <= b;
              area_ff <= ext_size;
              if (ext_present && (forbid || ext_size < EMHC_EXT_MIN || ext_size > EMHC_EXT_MAX
                || {frame_size[15:8], b} < {8'h00, ext_size})) begin
                hdr_error <= 1'b1;
                st_ff <= P_DROP;
              end else st_ff <= ext_present ? P_EH : P_H1;
            end
            P_EH: begin
              etype_ff <= b[7:4];
              esize_ff <= b[3:0];
              erem_ff <= {4'h0, b[3:0]};
              idx_ff <= 3'h0;
              val_ff <= 40'h0;
              e2e_ff <= b[7:4] >= EMHC_T_E2E_LO && b[7:4] <= EMHC_T_E2E_HI;
              // An element header on the last area byte cannot own payload
              if (last_area) st_ff <= P_H1;
              else if (b[7:4] == EMHC_T_ESC) st_ff <= P_XT;
              else if (b[3:0] != 4'h0) st_ff <= P_EV;
              else st_ff <= P_EH;
            end
            P_XT: begin
              xtype_ff <= b;
              st_ff <= last_area ? P_H1 : P_XL;
              erem_ff <= 8'h01;
            end
            P_XL, P_EV: begin
              if (st_ff == P_XL) erem_ff <= b;
              else begin
                erem_ff <= erem_ff - 8'h01;
                if (idx_ff != 3'h5) begin
                  val_ff <= {val_ff[31:0], b};
                  idx_ff <= idx_ff + 3'h1;
                end
              end
              if (last_area) st_ff <= P_H1;
              else if (st_ff == P_XL && b != 8'h00) st_ff <= P_EV;
              else if (st_ff == P_EV && erem_ff != 8'h01) st_ff <= P_EV;
              else st_ff <= P_EH;
            end
            P_H1: begin
              hcs_out[15:8] <= b;
              st_ff <= P_H2;
            end
            P_H2: begin
              hcs_out[7:0] <= b;
              hdr_valid <= 1'b1;
              st_ff <= P_PAY;
            end
            P_PAY: begin
              pay_valid <= 1'b1;
              pay_byte <= b;
            end
            P_DROP: st_ff <= P_DROP;
          endcase
          if (link.eof && st_ff != P_H2) st_ff <= P_FC;
        end
      end
    end
  end

  // Element report; payload left-aligned so short elements read from the top
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      elem_valid <= 1'b0;
      elem_kind <= EMHC_K_NONE;
      elem_type <= 4'h0;
      elem_etype <= 8'h00;
      elem_value <= 40'h0;
      elem_bad_size <= 1'b0;
      piggy_valid <= 1'b0;
      piggy_slots <= 8'h00;
    end else begin
      elem_valid <= 1'b0;
      piggy_valid <= 1'b0;
      elem_bad_size <= 1'b0;
      if (link.valid && !link.sof && elem_done && st_ff == P_EV) begin
        elem_kind <= kind_of(etype_ff, esize_ff);
        elem_type <= etype_ff;
        elem_etype <= xtype_ff;
        elem_value <= ({val_ff[31:0], b}) << (8 * (4 - 32'(idx_ff)));
        elem_valid <= kind_of(etype_ff, esize_ff) != EMHC_K_SKIP;
        elem_bad_size <= etype_ff < 4'h7 && etype_ff != EMHC_T_NULL &&
          kind_of(etype_ff, esize_ff) == EMHC_K_SKIP;
        // Piggyback slot count: first byte of request, fourth of privacy
        if (etype_ff == EMHC_T_REQ && esize_ff == EMHC_L_REQ) begin
          piggy_valid <= 1'b1;
          piggy_slots <= val_ff[15:8];
        end else if (etype_ff == EMHC_T_UPRIV && esize_ff == EMHC_L_PRIVFRAG) begin
          piggy_valid <= 1'b1;
          piggy_slots <= val_ff[7:0];
        end else if (etype_ff == EMHC_T_UPRIV && esize_ff == EMHC_L_PRIV) begin
          piggy_valid <= 1'b1;
          piggy_slots <= b;
        end
      end
    end
  end

  // End-to-end element bytes, type byte included, kept for forwarding
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fwd_valid <= 1'b0;
      fwd_byte <= 8'h00;
    end else begin
      fwd_valid <= link.valid && !link.sof && ((st_ff == P_EH && b[7:4] >= EMHC_T_E2E_LO &&
        b[7:4] <= EMHC_T_E2E_HI) || (st_ff == P_EV && e2e_ff));
      fwd_byte <= b;
    end
  end
endmodule // emhc_parser
`default_nettype wire

/* src/emhc_pkg.sv */
`default_nettype none
package emhc_pkg;
  // Frame control byte layout: type in 7:6, parameter in 5:1, extended-header flag in bit 0
  localparam int EMHC_FC_FLAG_BIT = 0;
  localparam logic [1:0] EMHC_FC_TYPE_MACSPEC = 2'h3;
  localparam logic [4:0] EMHC_PARM_TIMING = 5'h00;
  localparam logic [4:0] EMHC_PARM_REQ = 5'h02;
  localparam logic [4:0] EMHC_PARM_FRAG = 5'h03;
  localparam logic [4:0] EMHC_PARM_CONCAT = 5'h1C;
  // Extended header size limits
  localparam logic [7:0] EMHC_EXT_MIN = 8'h01;
  localparam logic [7:0] EMHC_EXT_MAX = 8'hF0;
  // Fixed header bytes around the extended area
  localparam logic [15:0] EMHC_HDR_FIXED = 16'h0006;
  // Element types
  localparam logic [3:0] EMHC_T_NULL = 4'h0;
  localparam logic [3:0] EMHC_T_REQ = 4'h1;
  localparam logic [3:0] EMHC_T_ACK = 4'h2;
  localparam logic [3:0] EMHC_T_UPRIV = 4'h3;
  localparam logic [3:0] EMHC_T_DPRIV = 4'h4;
  localparam logic [3:0] EMHC_T_DPHS = 4'h5;
  localparam logic [3:0] EMHC_T_UPHS = 4'h6;
  localparam logic [3:0] EMHC_T_E2E_LO = 4'hA;
  localparam logic [3:0] EMHC_T_E2E_HI = 4'hE;
  localparam logic [3:0] EMHC_T_ESC = 4'hF;
  // Element sizes
  localparam logic [3:0] EMHC_L_REQ = 4'h3;
  localparam logic [3:0] EMHC_L_ACK = 4'h2;
  localparam logic [3:0] EMHC_L_PRIV = 4'h4;
  localparam logic [3:0] EMHC_L_PRIVFRAG = 4'h5;
  localparam logic [3:0] EMHC_L_PHS = 4'h1;
  localparam logic [3:0] EMHC_L_PHSUGS = 4'h2;
  typedef enum logic [2:0] {
    EMHC_K_NONE, EMHC_K_REQ, EMHC_K_ACK, EMHC_K_UPRIV, EMHC_K_DPRIV, EMHC_K_PHS,
    EMHC_K_E2E, EMHC_K_SKIP
  } emhc_kind_t;
endpackage
`default_nettype wire

/* src/emhc_link_if.sv */
`default_nettype none
// Byte stream between the frame builder and the frame parser
interface emhc_link_if;
  logic [7:0] data; // Frame byte
  logic valid; // Byte present
  logic sof; // First byte of frame
  logic eof; // Last byte of frame
  modport tx (output data, output valid, output sof, output eof);
  modport rx (input data, input valid, input sof, input eof);
endinterface
`default_nettype wire

/* src/emhc_builder.sv */
`default_nettype none
// Frame builder: emits fc, parameter, size, extended bytes, check, payload
module emhc_builder (
  input wire logic sys_clk, // Clock
  input wire logic rstn, // Async reset, active low
  emhc_link_if.tx link, // Outgoing byte stream
  input wire logic start, // Pulse: begin frame with fields below
  input wire logic [7:0] fc_in, // Frame control byte, flag bit ignored
  input wire logic [7:0] parm_in, // Parameter byte used when no extension
  input wire logic [7:0] ext_size_in, // Extended header bytes, 0 for none
  input wire logic [15:0] pay_size_in, // Payload bytes
  input wire logic [15:0] hcs_in, // Header check sequence
  output logic ext_ready, // Next extended byte wanted
  input wire logic [7:0] ext_byte, // Extended byte from user
  output logic pay_ready, // Next payload byte wanted
  input wire logic [7:0] pay_byte, // Payload byte from user
  output logic busy, // Frame in progress
  output logic rejected // Pulse: illegal extended size or kind
);
  import emhc_pkg::*;
  typedef enum {S_IDLE, S_FC, S_PARM, S_LHI, S_LLO, S_EXT, S_H1, S_H2, S_PAY} emhc_bst_t;
  emhc_bst_t st_ff;
  logic [7:0] fc_ff, parm_ff, ext_ff;
  logic [15:0] pay_ff, len_ff, hcs_ff, cnt_ff;
  logic forbid, use_ext, ok;
  // Timing, concatenation and request headers never carry the area
  assign forbid = (fc_in[7:6] == EMHC_FC_TYPE_MACSPEC) && ((fc_in[5:1] == EMHC_PARM_TIMING) ||
    (fc_in[5:1] == EMHC_PARM_REQ) || (fc_in[5:1] == EMHC_PARM_CONCAT));
  assign use_ext = ext_size_in != 8'h00;
  assign ok = !use_ext || (!forbid && ext_size_in >= EMHC_EXT_MIN &&
    ext_size_in <= EMHC_EXT_MAX);
  assign ext_ready = st_ff == S_EXT;
  assign pay_ready = st_ff == S_PAY;
  assign busy = st_ff != S_IDLE;
  // Capture and sequence; user supplies bytes without stall, one per cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= S_IDLE;
      fc_ff <= 8'h00;
      parm_ff <= 8'h00;
      ext_ff <= 8'h00;
      pay_ff <= 16'h0000;
      len_ff <= 16'h0000;
      hcs_ff <= 16'h0000;
      cnt_ff <= 16'h0000;
      rejected <= 1'b0;
    end else begin
      rejected <= 1'b0;
      cnt_ff <= cnt_ff + 16'h0001;
      unique case (st_ff)
        S_IDLE: if (start) begin
          if (!ok) rejected <= 1'b1;
          else begin
            fc_ff <= {fc_in[7:1], use_ext};
            parm_ff <= use_ext ? ext_size_in : parm_in;
            ext_ff <= ext_size_in;
            pay_ff <= pay_size_in;
            len_ff <= {8'h00, ext_size_in} + pay_size_in;
            hcs_ff <= hcs_in;
            st_ff <= S_FC;
          end
        end
        S_FC: st_ff <= S_PARM;
        S_PARM: st_ff <= S_LHI;
        S_LHI: st_ff <= S_LLO;
        S_LLO: begin
          cnt_ff <= 16'h0000;
          st_ff <= (ext_ff != 8'h00) ? S_EXT : S_H1;
        end
        S_EXT: if (cnt_ff == {8'h00, ext_ff} - 16'h0001) st_ff <= S_H1;
        S_H1: st_ff <= S_H2;
        S_H2: begin
          cnt_ff <= 16'h0000;
          st_ff <= (pay_ff != 16'h0000) ? S_PAY : S_IDLE;
        end
        S_PAY: if (cnt_ff == pay_ff - 16'h0001) st_ff <= S_IDLE;
      endcase
    end
  end
  // Output byte register; one byte per cycle in documented order
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      link.data <= 8'h00;
      link.valid <= 1'b0;
      link.sof <= 1'b0;
      link.eof <= 1'b0;
    end else begin
      link.valid <= st_ff != S_IDLE;
      link.sof <= st_ff == S_FC;
      link.eof <= (st_ff == S_H2 && pay_ff == 16'h0000) ||
        (st_ff == S_PAY && cnt_ff == pay_ff - 16'h0001);
      unique case (st_ff)
        S_FC: link.data <= fc_ff;
        S_PARM: link.data <= parm_ff;
        S_LHI: link.data <= len_ff[15:8];
        S_LLO: link.data <= len_ff[7:0];
        S_EXT: link.data <= ext_byte;
        S_H1: link.data <= hcs_ff[15:8];
        S_H2: link.data <= hcs_ff[7:0];
        S_PAY: link.data <= pay_byte;
        default: link.data <= 8'h00;
      endcase
    end
  end
endmodule // emhc_builder
`default_nettype wire

/* tb/emhc_checker.sv */
`default_nettype none
// Watches the byte stream that joins builder and parser
module emhc_checker (
  input wire logic sys_clk, // Clock
  input wire logic rstn, // Async reset, active low
  input wire logic [7:0] data, // Frame byte
  input wire logic valid, // Byte present
  input wire logic sof, // First byte of frame
  input wire logic eof // Last byte of frame
);
  timeunit 1ns;
  timeprecision 1ns;
  import emhc_pkg::*;
  logic [15:0] idx_ff;
  logic [15:0] pos;
  logic [15:0] len_ff;
  logic [7:0] parm_ff;
  logic flag_ff;
  // Byte position; sof forces zero so a stale count cannot leak into the next frame
  assign pos = sof ? 16'h0000 : idx_ff;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      idx_ff <= 16'h0000;
    end else if (valid) begin
      idx_ff <= pos + 16'h0001;
    end
  end
  // Header fields kept for the length relations
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flag_ff <= 1'b0;
      parm_ff <= 8'h00;
      len_ff <= 16'h0000;
    end else if (valid) begin
      if (pos == 16'h0000) flag_ff <= data[EMHC_FC_FLAG_BIT];
      if (pos == 16'h0001) parm_ff <= data;
      if (pos == 16'h0002) len_ff[15:8] <= data;
      if (pos == 16'h0003) len_ff[7:0] <= data;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence flag_fc_s;
    valid && sof && data[EMHC_FC_FLAG_BIT];
  endsequence
  sequence no_area_fc_s;
    valid && sof && data[7:6] == EMHC_FC_TYPE_MACSPEC && (data[5:1] == EMHC_PARM_TIMING ||
      data[5:1] == EMHC_PARM_REQ || data[5:1] == EMHC_PARM_CONCAT);
  endsequence
  sequence len_done_s;
    valid && pos == 16'h0004 && flag_ff;
  endsequence
  sof_valid_a: assert property (sof |-> valid)
    else $error("sof without valid");
  eof_valid_a: assert property (eof |-> valid)
    else $error("eof without valid");
  burst_gap_a: assert property (valid && !eof |=> valid)
    else $error("gap inside frame");
  mid_sof_a: assert property (valid && !eof |=> !sof)
    else $error("new frame before eof");
  no_area_a: assert property (no_area_fc_s |-> !data[EMHC_FC_FLAG_BIT])
    else $error("area flag on forbidden header");
  ext_range_a: assert property (flag_fc_s |=>
      valid && data >= EMHC_EXT_MIN && data <= EMHC_EXT_MAX)
    else $error("area size out of range");
  area_in_len_a: assert property (len_done_s |-> len_ff >= {8'h00, parm_ff})
    else $error("frame size below area size");
  frame_len_a: assert property (valid && eof |->
      {1'b0, pos} + 17'h00001 == {1'b0, len_ff} + {1'b0, EMHC_HDR_FIXED})
    else $error("frame length disagrees with size field");
endmodule // emhc_checker
`default_nettype wire

/* tb/extended_mac_header_codec_test.sv */
`default_nettype none
module extended_mac_header_codec_test;
  timeunit 1ns;
  timeprecision 1ns;
  import emhc_pkg::*;
  logic sys_clk, rstn, start, ext_ready, pay_ready, busy, rejected, hdr_valid, ext_present;
  logic hdr_error, elem_valid, elem_bad_size, piggy_valid, fwd_valid, rx_valid, bad_err;
  logic [7:0] fc_in, parm_in, ext_size_in, ext_byte, pay_byte, fc_out, ext_size, piggy_slots;
  logic [7:0] fwd_byte, rx_byte, last_pay, last_fwd, last_slots;
  logic [7:0] ext_mem [0:255];
  logic [15:0] pay_size_in, hcs_in, frame_size, hcs_out, ei, pi, types_seen;
  logic [3:0] elem_type;
  logic [39:0] elem_value;
  logic [39:0] val_k [8];
  emhc_kind_t elem_kind;
  int err_total, checks_done, n_rej, n_sof, n_herr, n_bad, n_pig, n_fwd, n_pay, n_bherr, n_hdr;
  int n_kind [8];
  logic [4:0] no_area [3] = '{EMHC_PARM_TIMING, EMHC_PARM_REQ, EMHC_PARM_CONCAT};
  emhc_link_if link();
  emhc_link_if bad_link();
  emhc_builder i_emhc_builder (.sys_clk(sys_clk), .rstn(rstn), .link(link.tx), .start(start),
    .fc_in(fc_in), .parm_in(parm_in), .ext_size_in(ext_size_in), .pay_size_in(pay_size_in),
    .hcs_in(hcs_in), .ext_ready(ext_ready), .ext_byte(ext_byte), .pay_ready(pay_ready),
    .pay_byte(pay_byte), .busy(busy), .rejected(rejected));
  emhc_parser i_emhc_parser (.sys_clk(sys_clk), .rstn(rstn), .link(link.rx),
    .hdr_valid(hdr_valid), .fc_out(fc_out), .ext_present(ext_present), .ext_size(ext_size),
    .frame_size(frame_size), .hcs_out(hcs_out), .hdr_error(hdr_error), .elem_valid(elem_valid),
    .elem_kind(elem_kind), .elem_type(elem_type), .elem_etype(), .elem_value(elem_value),
    .elem_bad_size(elem_bad_size), .piggy_valid(piggy_valid), .piggy_slots(piggy_slots),
    .fwd_valid(fwd_valid), .fwd_byte(fwd_byte), .pay_valid(rx_valid), .pay_byte(rx_byte));
  // Second parser fed by hand with frames a builder must never send
  emhc_parser i_emhc_parser_bad (.sys_clk(sys_clk), .rstn(rstn), .link(bad_link.rx),
    .hdr_valid(), .fc_out(), .ext_present(), .ext_size(), .frame_size(), .hcs_out(),
    .hdr_error(bad_err), .elem_valid(), .elem_kind(), .elem_type(), .elem_etype(),
    .elem_value(), .elem_bad_size(), .piggy_valid(), .piggy_slots(), .fwd_valid(),
    .fwd_byte(), .pay_valid(), .pay_byte());
  emhc_checker i_emhc_checker (.sys_clk(sys_clk), .rstn(rstn), .data(link.data),
    .valid(link.valid), .sof(link.sof), .eof(link.eof));
  // Clock at 25 MHz
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // User bytes follow the ready strobes; payload is a counting pattern
  assign ext_byte = ext_mem[ei[7:0]];
  assign pay_byte = pi[7:0] + 8'h40;
  always @(posedge sys_clk) begin
    if (ext_ready === 1'b1) ei <= ei + 16'h0001;
    if (pay_ready === 1'b1) pi <= pi + 16'h0001;
  end
  // Tally of everything the parsers report; pulses are read at the edge that ends them
  always @(posedge sys_clk) begin
    if (rejected === 1'b1) n_rej++;
    if (link.valid === 1'b1 && link.sof === 1'b1) n_sof++;
    if (hdr_error === 1'b1) n_herr++;
    if (hdr_valid === 1'b1) n_hdr++;
    if (bad_err === 1'b1) n_bherr++;
    if (elem_bad_size === 1'b1) n_bad++;
    if (elem_valid === 1'b1) begin
      n_kind[elem_kind]++;
      types_seen[elem_type] = 1'b1;
      val_k[elem_kind] = elem_value;
    end
    if (piggy_valid === 1'b1) begin
      n_pig++;
      last_slots = piggy_slots;
    end
    if (fwd_valid === 1'b1) begin
      n_fwd++;
      last_fwd = fwd_byte;
    end
    if (rx_valid === 1'b1) begin
      n_pay++;
      last_pay = rx_byte;
    end
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: value %0h, wanted %0h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    chk(40'(got), 40'(exp));
  endtask
  task automatic load(input logic [255:0] v, input int n);
    for (int i = 0; i < 256; i++) ext_mem[i] = (i < n) ? v[8 * (n - 1 - i) +: 8] : 8'h00;
  endtask
  // One frame through the builder; waits for busy to fall, then lets the parser finish
  task automatic send(input logic [7:0] fc, parm, esz, input logic [15:0] psz);
    {n_rej, n_sof, n_herr, n_bad, n_pig, n_fwd, n_pay, n_hdr} = '0;
    n_kind = '{default: 0};
    types_seen = 16'h0000;
    fc_in = fc;
    parm_in = parm;
    ext_size_in = esz;
    pay_size_in = psz;
    hcs_in = 16'hC3A5;
    ei = 16'h0000;
    pi = 16'h0000;
    start = 1'b1;
    @(posedge sys_clk);
    #1 start = 1'b0;
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  // Six header bytes on the spare link; released data shows the inverse
  task automatic raw(input logic [47:0] v);
    n_bherr = 0;
    for (int i = 0; i < 6; i++) begin
      bad_link.data = v[47 - 8 * i -: 8];
      bad_link.valid = 1'b1;
      bad_link.sof = (i == 0);
      bad_link.eof = (i == 5);
      @(posedge sys_clk);
      #1;
    end
    {bad_link.valid, bad_link.sof, bad_link.eof} = 3'h0;
    bad_link.data = ~bad_link.data;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task summarize();
    $display("comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Limit well above the few hundred cycles the tests need
  initial begin
    #(40 * 8000);
    err_total++;
    summarize();
  end
  initial begin
    {start, fc_in, parm_in, ext_size_in, pay_size_in, hcs_in, ei, pi} = '0;
    {bad_link.data, bad_link.valid, bad_link.sof, bad_link.eof} = '0;
    {err_total, checks_done} = '0;
    load(256'h0, 0);
    rstn = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 rstn = 1'b1;
    send(8'h00, 8'h00, 8'h00, 16'h0004);
    chk_n(n_sof, 1);
    chk_n(n_hdr, 1);
    chk(ext_present, 1'b0);
    chk(frame_size, 16'h0004);
    chk(hcs_out, 16'hC3A5);
    chk_n(n_pay, 4);
    chk(last_pay, 8'h43);
    load(256'h132A123400721122225678A177F00102AABB, 18);
    send(8'h00, 8'h00, 8'd18, 16'h0002);
    chk(fc_out, 8'h01);
    chk(ext_size, 8'd18);
    chk(frame_size, 16'd20);
    chk_n(n_kind[EMHC_K_REQ], 1);
    chk(val_k[EMHC_K_REQ][39:16], 24'h2A1234);
    chk(val_k[EMHC_K_ACK][39:24], 16'h5678);
    chk(last_slots, 8'h2A);
    chk(types_seen[7], 1'b0);
    chk(types_seen[15], 1'b0);
    chk(last_fwd, 8'h77);
    chk_n(n_pay, 2);
    chk_n(n_herr + n_bad, 0);
    load(256'h120102_34A0B0C033_44D0D1D2D3_5109_620506, 18);
    send(8'h00, 8'h00, 8'd18, 16'h0000);
    chk_n(n_bad, 1);
    chk_n(n_kind[EMHC_K_REQ], 0);
    chk_n(n_kind[EMHC_K_UPRIV], 1);
    chk_n(n_kind[EMHC_K_DPRIV], 1);
    chk_n(n_kind[EMHC_K_PHS], 2);
    chk(val_k[EMHC_K_PHS][39:24], 16'h0506);
    chk_n(n_pig, 1);
    chk(last_slots, 8'h33);
    for (int j = 0; j < 3; j++) begin
      send({EMHC_FC_TYPE_MACSPEC, no_area[j], 1'b0}, 8'h00, 8'h04, 16'h0000);
      chk_n(n_rej + 2 * n_sof, 1);
    end
    send({EMHC_FC_TYPE_MACSPEC, EMHC_PARM_TIMING, 1'b0}, 8'h00, 8'h00, 16'h0000);
    chk_n(n_rej + 2 * n_sof, 2);
    send(8'h00, 8'h00, 8'd241, 16'h0000);
    chk_n(n_rej + 2 * n_sof, 1);
    load(256'h0, 0);
    send(8'h00, 8'h00, 8'd240, 16'h0000);
    chk(ext_size, 8'd240);
    chk_n(n_herr + n_rej, 0);
    raw(48'h01F100F11234);
    chk_n(n_bherr, 1);
    raw(48'h010000001234);
    chk_n(n_bherr, 1);
    summarize();
  end
endmodule // extended_mac_header_codec_test
`default_nettype wire
